// file: core/xcp_pkg.sv
// Package of register map, field layout and carrier types for the crystal pulling control
package xcp_pkg;

    // ==========================================================
    // Register offsets (byte addresses on the register port)
    localparam logic [7:0] XCP_OFS_TX_CONFIG   = 8'hae;
    localparam logic [7:0] XCP_OFS_UPPER_CAP   = 8'hc3;
    localparam logic [7:0] XCP_OFS_LOWER_CAP   = 8'hc2;
    localparam logic [7:0] XCP_OFS_TX_CONTROL  = 8'hc8;
    localparam logic [7:0] XCP_OFS_TX_STATUS   = 8'hc9;
    localparam logic [7:0] XCP_OFS_TX_DATA     = 8'hca;
    localparam logic [7:0] XCP_OFS_VCO_CURVE   = 8'hcb;

    // ==========================================================
    // Reset values
    localparam logic [7:0] XCP_RST_TX_CONFIG   = 8'h87;
    localparam logic [7:0] XCP_RST_TX_CONTROL  = 8'h00;
    localparam logic [7:0] XCP_RST_CAP_CODE    = 8'hff;
    localparam logic [7:0] XCP_RST_VCO_CURVE   = 8'h00;

    // ==========================================================
    // Writable bit masks; unused bits read as zero
    localparam logic [7:0] XCP_MSK_TX_CONFIG   = 8'hef;
    localparam logic [7:0] XCP_MSK_TX_CONTROL  = 8'h83;
    localparam logic [7:0] XCP_MSK_FULL        = 8'hff;
    localparam logic [7:0] XCP_MSK_VCO_CURVE   = 8'h0f;

    // ==========================================================
    // Field positions
    localparam int XCP_CFG_EXT_SWITCH   = 7;
    localparam int XCP_CFG_INVERT_DATA  = 6;
    localparam int XCP_CFG_MOD_SELECT   = 5;
    localparam int XCP_CFG_BAND_HI      = 3;
    localparam int XCP_CFG_BAND_LO      = 2;
    localparam int XCP_CFG_STAGE_HI     = 1;
    localparam int XCP_CFG_STAGE_LO     = 0;
    localparam int XCP_CTL_LOCK_MON     = 7;
    localparam int XCP_CTL_SYNTH_EN     = 1;
    localparam int XCP_CTL_MANUAL_AMP   = 0;
    localparam int XCP_STS_AMP_DISABLED = 7;
    localparam int XCP_STS_TX_ACTIVE    = 0;

    // ==========================================================
    // Band and output stage codes
    localparam logic [1:0] XCP_BAND_LOW_CODE   = 2'h0;
    localparam logic [1:0] XCP_BAND_HIGH_CODE  = 2'h1;
    localparam logic [1:0] XCP_STAGE_ONE_CODE  = 2'h0;
    localparam logic [1:0] XCP_STAGE_THREE_CODE = 2'h3;
    localparam logic [2:0] XCP_STAGES_ONE      = 3'h1;
    localparam logic [2:0] XCP_STAGES_TWO      = 3'h3;
    localparam logic [2:0] XCP_STAGES_THREE    = 3'h7;

    // ==========================================================
    // Transmission tracking states
    typedef enum logic [1:0] {
        XCP_TX_IDLE  = 2'b00,
        XCP_TX_START = 2'b01,
        XCP_TX_SEND  = 2'b10
    } xcp_tx_state_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       wrStb;
        logic       rdStb;
    } xcp_bus_req_t;

    typedef struct packed {
        logic       encBit;
        logic       shiftBusy;
        logic       pllLocked;
    } xcp_enc_in_t;

    typedef struct packed {
        logic [7:0] capCode;
        logic       extSwitchClosed;
        logic       ampEnable;
        logic       synthEnable;
        logic       bandLowSel;
        logic       bandHighSel;
        logic [2:0] stageEnable;
        logic [3:0] vcoCurve;
    } xcp_rf_out_t;

endpackage

// file: core/xcp_byte_reg.sv
// Byte-wide software register with reset value and writable-bit mask
`timescale 1ns/10ps

module xcp_byte_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK   = 8'hff
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    output logic      [7:0] value
);

    logic [7:0] value_reg;
    logic [7:0] value_next;

    always_comb begin
        value_next = value_reg;
        if (wrEn) begin
            value_next = wrData & WR_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            value_reg <= RESET_VAL & WR_MASK;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

endmodule

// file: core/xcp_tx_ctrl.sv
// Transmitter control: crystal pulling selection, amplifier control and lock monitor
`timescale 1ns/10ps

// What this block does
// - FSK internal: bit 0 lower, 1 upper code
// - External FSK: switch closed on 0, open 1
// - ASK: amplifier follows encoder bit
// - Automatic: data write turns amplifier on
// - Automatic: amplifier off when shift register empties
// - Manual control bit overrides encoder amplifier drive
// - Synth and amplifier enables written independently
// - Lock loss with monitor: amplifier off, flag
// - Flag stays clear while lock held
// - Encoder keeps running after forced amplifier off
// - Band from configuration bits 3-2
// - Output power from configuration bits 1-0
// - Sixteen VCO tuning curves selectable
// - Lower code register, 8 bits, reset FF
// - Upper/carrier code register at C3, reset FF
// - Band 00 low band, 01 high, others reserved
// - Stage 00 one, 01/10 two, 11 three
// - ASK holds switch closed
module xcp_tx_ctrl (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire xcp_pkg::xcp_bus_req_t busReq,
    output logic                [7:0] busRdData,
    input  wire xcp_pkg::xcp_enc_in_t  encIn,
    output logic                [7:0] txDataByte,
    output logic                      txDataLoad,
    output xcp_pkg::xcp_rf_out_t      rfOut
);

    import xcp_pkg::*;

    // ==========================================================
    // Register file
    logic [7:0] txConfig;
    logic [7:0] txControl;
    logic [7:0] upperCapCode;
    logic [7:0] lowerCapCode;
    logic [7:0] vcoCurveReg;
    logic       wrConfig;
    logic       wrControl;
    logic       wrUpper;
    logic       wrLower;
    logic       wrVco;
    logic       wrStatus;
    logic       wrData;

    // Unmapped offsets leave every strobe low, so such writes are ignored
    always_comb begin
        wrConfig  = 1'b0;
        wrControl = 1'b0;
        wrUpper   = 1'b0;
        wrLower   = 1'b0;
        wrVco     = 1'b0;
        wrStatus  = 1'b0;
        wrData    = 1'b0;
        if (busReq.wrStb) begin
            unique case (busReq.addr)
                XCP_OFS_TX_CONFIG:  wrConfig  = 1'b1;
                XCP_OFS_TX_CONTROL: wrControl = 1'b1;
                XCP_OFS_UPPER_CAP:  wrUpper   = 1'b1;
                XCP_OFS_LOWER_CAP:  wrLower   = 1'b1;
                XCP_OFS_VCO_CURVE:  wrVco     = 1'b1;
                XCP_OFS_TX_STATUS:  wrStatus  = 1'b1;
                XCP_OFS_TX_DATA:    wrData    = 1'b1;
                default:            wrData    = 1'b0;
            endcase
        end
    end

    xcp_byte_reg #(
        .RESET_VAL (XCP_RST_TX_CONFIG),
        .WR_MASK   (XCP_MSK_TX_CONFIG)
    ) u_config (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wrEn     (wrConfig),
        .wrData   (busReq.wrData),
        .value    (txConfig)
    );

    xcp_byte_reg #(
        .RESET_VAL (XCP_RST_TX_CONTROL),
        .WR_MASK   (XCP_MSK_TX_CONTROL)
    ) u_control (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wrEn     (wrControl),
        .wrData   (busReq.wrData),
        .value    (txControl)
    );

    xcp_byte_reg #(
        .RESET_VAL (XCP_RST_CAP_CODE),
        .WR_MASK   (XCP_MSK_FULL)
    ) u_upper_cap (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wrEn     (wrUpper),
        .wrData   (busReq.wrData),
        .value    (upperCapCode)
    );

    xcp_byte_reg #(
        .RESET_VAL (XCP_RST_CAP_CODE),
        .WR_MASK   (XCP_MSK_FULL)
    ) u_lower_cap (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wrEn     (wrLower),
        .wrData   (busReq.wrData),
        .value    (lowerCapCode)
    );

    xcp_byte_reg #(
        .RESET_VAL (XCP_RST_VCO_CURVE),
        .WR_MASK   (XCP_MSK_VCO_CURVE)
    ) u_vco_curve (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wrEn     (wrVco),
        .wrData   (busReq.wrData),
        .value    (vcoCurveReg)
    );

    // ==========================================================
    // Field views
    logic       extSwitchCtl;
    logic       invertData;
    logic       askMode;
    logic [1:0] bandField;
    logic [1:0] stageField;
    logic       lockMonEn;
    logic       synthEn;
    logic       manualAmp;
    logic       txBit;

    assign extSwitchCtl = txConfig[XCP_CFG_EXT_SWITCH];
    assign invertData   = txConfig[XCP_CFG_INVERT_DATA];
    assign askMode      = txConfig[XCP_CFG_MOD_SELECT];
    assign bandField    = txConfig[XCP_CFG_BAND_HI:XCP_CFG_BAND_LO];
    assign stageField   = txConfig[XCP_CFG_STAGE_HI:XCP_CFG_STAGE_LO];
    assign lockMonEn    = txControl[XCP_CTL_LOCK_MON];
    assign synthEn      = txControl[XCP_CTL_SYNTH_EN];
    assign manualAmp    = txControl[XCP_CTL_MANUAL_AMP];
    assign txBit        = encIn.encBit ^ invertData;

    // ==========================================================
    // Transmission tracking and lock monitor
    xcp_tx_state_t txState_reg;
    xcp_tx_state_t txState_next;
    logic          ampDisabled_reg;
    logic          ampDisabled_next;
    logic          lockLoss;
    logic          txActive;
    logic          flagClear;
    logic          newTx;

    // The encoder may need a cycle to raise its busy level after the load,
    // so START waits for busy before the empty shift register can end it.
    always_comb begin
        txState_next = txState_reg;
        unique case (txState_reg)
            XCP_TX_IDLE: begin
                if (wrData) begin
                    txState_next = XCP_TX_START;
                end
            end
            XCP_TX_START: begin
                if (encIn.shiftBusy) begin
                    txState_next = XCP_TX_SEND;
                end
            end
            XCP_TX_SEND: begin
                if (wrData) begin
                    txState_next = XCP_TX_START;
                end else if (!encIn.shiftBusy) begin
                    txState_next = XCP_TX_IDLE;
                end
            end
            default: begin
                txState_next = XCP_TX_IDLE;
            end
        endcase
    end

    assign txActive = (txState_reg != XCP_TX_IDLE);
    // Loss is only judged during a transmission or while the manual amplifier bit is set
    assign lockLoss = lockMonEn && !encIn.pllLocked && (txActive || manualAmp);

    // A data write from idle opens a new transmission and a new verdict
    assign newTx     = wrData && (txState_reg == XCP_TX_IDLE);
    assign flagClear = wrStatus && busReq.wrData[XCP_STS_AMP_DISABLED];

    always_comb begin
        ampDisabled_next = ampDisabled_reg;
        if (flagClear) begin
            ampDisabled_next = 1'b0;
        end
        if (newTx) begin
            ampDisabled_next = 1'b0;
        end
        // Set wins over any clear in the same cycle
        if (lockLoss) begin
            ampDisabled_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            txState_reg     <= XCP_TX_IDLE;
            ampDisabled_reg <= 1'b0;
        end else begin
            txState_reg     <= txState_next;
            ampDisabled_reg <= ampDisabled_next;
        end
    end

    // ==========================================================
    // RF side outputs, all registered
    xcp_rf_out_t rfOut_reg;
    xcp_rf_out_t rfOut_next;
    logic        ampWanted;
    logic        autoAmpOn;

    // The write cycle counts as well, so the amplifier rises with the data hand-off
    assign autoAmpOn = txActive || wrData;

    always_comb begin
        if (manualAmp) begin
            ampWanted = 1'b1;
        end else if (askMode) begin
            ampWanted = txActive && txBit;
        end else begin
            ampWanted = autoAmpOn;
        end
    end

    always_comb begin
        rfOut_next = rfOut_reg;
        // Forced off only gates the amplifier; the encoder is untouched
        rfOut_next.ampEnable   = ampWanted && !ampDisabled_next;
        rfOut_next.synthEnable = synthEn;
        if (askMode) begin
            rfOut_next.capCode         = upperCapCode;
            rfOut_next.extSwitchClosed = 1'b1;
        end else begin
            rfOut_next.capCode         = txBit ? upperCapCode : lowerCapCode;
            rfOut_next.extSwitchClosed = extSwitchCtl && !txBit;
        end
        // Reserved band codes leave both selects low
        rfOut_next.bandLowSel  = (bandField == XCP_BAND_LOW_CODE);
        rfOut_next.bandHighSel = (bandField == XCP_BAND_HIGH_CODE);
        // Both middle codes give two stages
        unique case (stageField)
            XCP_STAGE_ONE_CODE: begin
                rfOut_next.stageEnable = XCP_STAGES_ONE;
            end
            XCP_STAGE_THREE_CODE: begin
                rfOut_next.stageEnable = XCP_STAGES_THREE;
            end
            default: begin
                rfOut_next.stageEnable = XCP_STAGES_TWO;
            end
        endcase
        rfOut_next.vcoCurve = vcoCurveReg[3:0];
    end

    // Reset holds every RF control low; the settings show one edge after release
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rfOut_reg <= '0;
        end else begin
            rfOut_reg <= rfOut_next;
        end
    end

    assign rfOut = rfOut_reg;

    // ==========================================================
    // Transmit data hand-off and read port
    logic [7:0] txDataByte_reg;
    logic [7:0] txDataByte_next;
    logic       txDataLoad_reg;
    logic       txDataLoad_next;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    logic [7:0] statusValue;

    always_comb begin
        statusValue = 8'h00;
        statusValue[XCP_STS_AMP_DISABLED] = ampDisabled_reg;
        statusValue[XCP_STS_TX_ACTIVE]    = txActive;
    end

    always_comb begin
        txDataByte_next = txDataByte_reg;
        txDataLoad_next = 1'b0;
        rdData_next     = 8'h00;
        if (wrData) begin
            txDataByte_next = busReq.wrData;
            txDataLoad_next = 1'b1;
        end
        // Capacitor codes and data are write-only and read as zero
        if (busReq.rdStb) begin
            unique case (busReq.addr)
                XCP_OFS_TX_CONFIG:  rdData_next = txConfig;
                XCP_OFS_TX_CONTROL: rdData_next = txControl;
                XCP_OFS_TX_STATUS:  rdData_next = statusValue;
                XCP_OFS_VCO_CURVE:  rdData_next = vcoCurveReg;
                default:            rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            txDataByte_reg <= 8'h00;
            txDataLoad_reg <= 1'b0;
            rdData_reg     <= 8'h00;
        end else begin
            txDataByte_reg <= txDataByte_next;
            txDataLoad_reg <= txDataLoad_next;
            rdData_reg     <= rdData_next;
        end
    end

    assign txDataByte = txDataByte_reg;
    assign txDataLoad = txDataLoad_reg;
    assign busRdData  = rdData_reg;

endmodule

// file: dv/xcp_enc_model.sv
// Behavioural encoder shift register and lock source facing the transmitter control
`timescale 1ns/10ps

module xcp_enc_model (
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    input  wire logic      [7:0] txDataByte,
    input  wire logic            txDataLoad,
    input  wire logic            idleBit,
    input  wire logic            lockOk,
    input  wire logic      [1:0] bitLen,
    output xcp_pkg::xcp_enc_in_t encIn
);
    import xcp_pkg::*;
    logic [7:0] shiftReg;
    logic [3:0] bitsLeft;
    logic [1:0] holdCnt;
    // ==========================================================
    // Frame runs on even with the amplifier forced off, as the real encoder does
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bitsLeft <= 4'h0;
        end else if (txDataLoad) begin
            shiftReg <= txDataByte;
            bitsLeft <= 4'h8;
            holdCnt  <= bitLen;
        end else if (bitsLeft != 4'h0) begin
            holdCnt  <= (holdCnt == 2'h0) ? bitLen : holdCnt - 2'h1;
            shiftReg <= (holdCnt == 2'h0) ? {shiftReg[6:0], 1'b0} : shiftReg;
            bitsLeft <= (holdCnt == 2'h0) ? bitsLeft - 4'h1 : bitsLeft;
        end
    end
    assign encIn = {(bitsLeft != 4'h0) ? shiftReg[7] : idleBit, bitsLeft != 4'h0, lockOk};
endmodule

// file: dv/xcp_tx_ctrl_checker.sv
// Port-level assertions for the transmitter control block
`timescale 1ns/10ps

module xcp_tx_ctrl_checker (
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire xcp_pkg::xcp_bus_req_t busReq,
    input wire logic            [7:0] busRdData,
    input wire xcp_pkg::xcp_enc_in_t  encIn,
    input wire logic            [7:0] txDataByte,
    input wire logic                  txDataLoad,
    input wire xcp_pkg::xcp_rf_out_t  rfOut
);
    import xcp_pkg::*;
    logic [7:0] cfgS, ctlS, upS, loS;
    logic [1:0] upCnt;
    logic       wrCa, txBit, live;
    assign wrCa  = busReq.wrStb && busReq.addr == XCP_OFS_TX_DATA;
    assign txBit = encIn.encBit ^ cfgS[XCP_CFG_INVERT_DATA];
    // Live-gated output checks start only from the fourth edge after reset
    assign live  = upCnt == 2'h3;
    // ==========================================================
    // Register shadow
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfgS  <= XCP_RST_TX_CONFIG;
            ctlS  <= XCP_RST_TX_CONTROL;
            upS   <= XCP_RST_CAP_CODE;
            loS   <= XCP_RST_CAP_CODE;
            upCnt <= 2'h0;
        end else begin
            upCnt <= live ? upCnt : upCnt + 2'h1;
            if (busReq.wrStb && busReq.addr == XCP_OFS_TX_CONFIG) cfgS <= busReq.wrData;
            if (busReq.wrStb && busReq.addr == XCP_OFS_TX_CONTROL) ctlS <= busReq.wrData;
            if (busReq.wrStb && busReq.addr == XCP_OFS_UPPER_CAP) upS <= busReq.wrData;
            if (busReq.wrStb && busReq.addr == XCP_OFS_LOWER_CAP) loS <= busReq.wrData;
        end
    end
    function automatic logic [2:0] stages(input logic [1:0] code);
        if (code == XCP_STAGE_ONE_CODE) return XCP_STAGES_ONE;
        if (code == XCP_STAGE_THREE_CODE) return XCP_STAGES_THREE;
        return XCP_STAGES_TWO;
    endfunction
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Assertions
    load_pulse_a: assert property (wrCa |=> txDataLoad &&
        txDataByte == $past(busReq.wrData)) else $error("data byte not loaded");
    auto_on_a: assert property (live && wrCa && ctlS == 8'h00 && !cfgS[5]
        |=> rfOut.ampEnable) else $error("amplifier not started");
    auto_off_a: assert property (live && $fell(encIn.shiftBusy) && !ctlS[0] && !wrCa
        |-> ##2 !rfOut.ampEnable) else $error("amplifier not stopped");
    manual_amp_a: assert property (live && ctlS[0] && !ctlS[7] |=> rfOut.ampEnable)
        else $error("manual amplifier off");
    lock_cut_a: assert property (ctlS[7] && !encIn.pllLocked && rfOut.ampEnable
        |=> !rfOut.ampEnable) else $error("amplifier kept on after lock loss");
    fsk_cap_a: assert property (live && !cfgS[5] |=> rfOut.capCode ==
        ($past(txBit) ? $past(upS) : $past(loS))) else $error("wrong shift code");
    fsk_switch_a: assert property (live && !cfgS[5] |=> rfOut.extSwitchClosed ==
        ($past(cfgS[7]) && !$past(txBit))) else $error("wrong switch state");
    ask_hold_a: assert property (live && cfgS[5] |=> rfOut.extSwitchClosed &&
        rfOut.capCode == $past(upS)) else $error("carrier setting not held");
    band_dec_a: assert property (live |=> rfOut.bandLowSel == ($past(cfgS[3:2]) == 2'h0) &&
        rfOut.bandHighSel == ($past(cfgS[3:2]) == 2'h1)) else $error("band decode wrong");
    stage_dec_a: assert property (live |=> rfOut.stageEnable == stages($past(cfgS[1:0])))
        else $error("stage decode wrong");
    synth_en_a: assert property (live |=> rfOut.synthEnable == $past(ctlS[1]))
        else $error("synthesizer enable wrong");
    rd_idle_a: assert property (!busReq.rdStb |=> busRdData == 8'h00)
        else $error("read data not cleared");
    tx_start_c: cover property (wrCa ##1 txDataLoad);
    lock_cut_c: cover property (ctlS[7] && !encIn.pllLocked && rfOut.ampEnable);
    ask_tx_c: cover property (cfgS[5] && encIn.shiftBusy);
endmodule

bind xcp_tx_ctrl xcp_tx_ctrl_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .busReq(busReq), .busRdData(busRdData), .encIn(encIn), .txDataByte(txDataByte),
    .txDataLoad(txDataLoad), .rfOut(rfOut));

// file: dv/xcp_tx_ctrl_tb_top.sv
// Self-checking bench for the transmitter control block
`timescale 1ns/10ps

module xcp_tx_ctrl_tb_top;
    import xcp_pkg::*;
    logic               core_clk = 1'b0;
    logic               rst_n = 1'b0;
    xcp_bus_req_t       busReq = '0;
    logic         [7:0] busRdData, txDataByte;
    logic               txDataLoad, idleBit = 1'b0, lockOk = 1'b1, b, txBit;
    xcp_enc_in_t        encIn;
    xcp_rf_out_t        rfOut;
    logic         [1:0] bitLen = 2'h0;
    logic         [7:0] cfg, ctl, up, lo, vco;
    int                 n_fail = 0, total_checks = 0, cyc = 0;

    xcp_tx_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .busReq(busReq),
        .busRdData(busRdData), .encIn(encIn), .txDataByte(txDataByte),
        .txDataLoad(txDataLoad), .rfOut(rfOut));
    xcp_enc_model u_enc (.core_clk(core_clk), .rst_n(rst_n), .txDataByte(txDataByte),
        .txDataLoad(txDataLoad), .idleBit(idleBit), .lockOk(lockOk), .bitLen(bitLen),
        .encIn(encIn));

    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // Hang guard, far above the few thousand cycles the sequence needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        busReq.addr <= a;
        busReq.wrData <= d;
        busReq.wrStb <= 1'b1;
        @(posedge core_clk);
        busReq.wrStb <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        busReq.addr <= a;
        busReq.rdStb <= 1'b1;
        @(posedge core_clk);
        busReq.rdStb <= 1'b0;
        #1;
        check(busRdData, exp);
    endtask
    task automatic waitBusy(input logic lvl);
        for (int n = 0; n < 100 && encIn.shiftBusy !== lvl; n++) step();
    endtask
    // ==========================================================
    // Sequence
    initial begin
        void'($urandom(44241));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) step();
        check(rfOut.capCode, XCP_RST_CAP_CODE);
        rdc(XCP_OFS_TX_CONFIG, XCP_RST_TX_CONFIG);
        rdc(XCP_OFS_TX_CONTROL, XCP_RST_TX_CONTROL);
        rdc(XCP_OFS_VCO_CURVE, XCP_RST_VCO_CURVE);
        wr(XCP_OFS_TX_STATUS, 8'h7f);
        rdc(XCP_OFS_TX_STATUS, 8'h00);
        wr(8'h01, 8'hff);
        rdc(8'h01, 8'h00);
        wr(XCP_OFS_TX_CONTROL, 8'h02);
        repeat (2000) step();
        wr(XCP_OFS_TX_CONTROL, 8'h03);
        step();
        check({rfOut.synthEnable, rfOut.ampEnable}, 8'h03);
        for (int i = 0; i < 16; i++) begin
            cfg = {3'($urandom), 1'b0, 4'(i)};
            ctl = 8'($urandom) & XCP_MSK_TX_CONTROL;
            up = 8'($urandom);
            lo = 8'($urandom);
            vco = 8'($urandom) & XCP_MSK_VCO_CURVE;
            wr(XCP_OFS_UPPER_CAP, up);
            wr(XCP_OFS_LOWER_CAP, lo);
            wr(XCP_OFS_VCO_CURVE, vco);
            wr(XCP_OFS_TX_CONTROL, ctl);
            wr(XCP_OFS_TX_CONFIG, cfg);
            @(posedge core_clk);
            idleBit <= 1'($urandom);
            repeat (2) step();
            txBit = idleBit ^ cfg[XCP_CFG_INVERT_DATA];
            check(rfOut.capCode, (cfg[5] || txBit) ? up : lo);
            check(rfOut.extSwitchClosed, cfg[5] || (cfg[7] && !txBit));
            check({rfOut.synthEnable, rfOut.ampEnable}, ctl[1:0]);
            check({rfOut.bandHighSel, rfOut.bandLowSel}, {cfg[3:2] == 2'h1, cfg[3:2] == 2'h0});
            check(rfOut.stageEnable, cfg[1:0] == 2'h0 ? XCP_STAGES_ONE :
                cfg[1:0] == 2'h3 ? XCP_STAGES_THREE : XCP_STAGES_TWO);
            check(rfOut.vcoCurve, vco);
            rdc(XCP_OFS_TX_CONFIG, cfg);
            rdc(XCP_OFS_TX_CONTROL, ctl);
        end
        wr(XCP_OFS_TX_CONTROL, 8'h00);
        wr(XCP_OFS_TX_CONFIG, 8'h03);
        wr(XCP_OFS_TX_DATA, 8'h96);
        check({txDataLoad, rfOut.ampEnable}, 8'h03);
        check(txDataByte, 8'h96);
        waitBusy(1'b1);
        waitBusy(1'b0);
        step();
        check(rfOut.ampEnable, 1'b1);
        step();
        check(rfOut.ampEnable, 1'b0);
        rdc(XCP_OFS_TX_STATUS, 8'h00);
        wr(XCP_OFS_TX_CONTROL, 8'h80);
        wr(XCP_OFS_TX_CONFIG, 8'h83);
        bitLen <= 2'h2;
        wr(XCP_OFS_TX_DATA, 8'ha5);
        waitBusy(1'b1);
        @(posedge core_clk);
        lockOk <= 1'b0;
        step();
        check(rfOut.ampEnable, 1'b0);
        rdc(XCP_OFS_TX_STATUS, 8'h81);
        @(posedge core_clk);
        lockOk <= 1'b1;
        waitBusy(1'b0);
        step();
        check(rfOut.ampEnable, 1'b0);
        rdc(XCP_OFS_TX_STATUS, 8'h80);
        wr(XCP_OFS_TX_STATUS, 8'h80);
        rdc(XCP_OFS_TX_STATUS, 8'h00);
        wr(XCP_OFS_TX_CONTROL, 8'h00);
        wr(XCP_OFS_UPPER_CAP, 8'h00);
        wr(XCP_OFS_TX_CONFIG, 8'h20);
        bitLen <= 2'h1;
        wr(XCP_OFS_TX_DATA, 8'h5a);
        waitBusy(1'b1);
        repeat (2) step();
        for (int i = 0; i < 8; i++) begin
            b = encIn.encBit;
            step();
            check(rfOut.ampEnable, b);
            check(rfOut.capCode, 8'h00);
        end
        stop_test();
    end
endmodule
